// ---- src/gpj_pkg.sv ----
// Package for the five-bit port: register map, field layouts and state types
package gpj_pkg;
   localparam int GPJ_NPINS = 5;
   localparam logic [11:0] GPJ_OFS_DATA = 12'h000;
   localparam logic [11:0] GPJ_OFS_OE = 12'h004;
   localparam logic [11:0] GPJ_OFS_FUNC = 12'h008;
   localparam logic [11:0] GPJ_OFS_RSVD = 12'h010;
   localparam logic [11:0] GPJ_OFS_PUP = 12'h02c;
   localparam logic [11:0] GPJ_OFS_IE = 12'h038;
   localparam logic [11:0] GPJ_OFS_IRQ_STAT = 12'h040;
   localparam logic [11:0] GPJ_OFS_IRQ_MASK = 12'h044;
   localparam logic [11:0] GPJ_OFS_CTRL = 12'h048;
   localparam logic [31:0] GPJ_BASE_ADDR = 32'h4000_0240;
   localparam logic [11:0] GPJ_ADDR_MASK = 12'hfff;
   localparam logic [7:0] GPJ_WBYTE_MASK = 8'hff;
   localparam logic [4:0] GPJ_RESET_BITS = 5'h00;
   localparam int GPJ_TIMER_PIN = 4;
   localparam int GPJ_NIRQ = 4;
   localparam int GPJ_CTRL_STOP_BIT = 0;
   localparam int GPJ_CTRL_DRV_BIT = 1;
   localparam logic [1:0] GPJ_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] GPJ_HTRANS_SEQ = 2'h3;

   typedef enum logic [1:0] {
      GPJ_IDLE = 2'h0,
      GPJ_WDATA = 2'h1,
      GPJ_RDATA = 2'h3
   } gpj_phase_t;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] oe;
      logic [7:0] func;
      logic [7:0] pup;
      logic [7:0] ie;
   } gpj_regs_t;

   typedef struct packed {
      logic [4:0] out;
      logic [4:0] oe;
      logic [4:0] pup;
      logic [4:0] ibuf;
   } gpj_pad_t;
endpackage

// ---- src/gpj_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module gpj_sync
   import gpj_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Pins in, filtered level out
   input wire logic [GPJ_NPINS-1:0] din,
   output logic [GPJ_NPINS-1:0] dout
);
   typedef struct packed {
      logic [GPJ_NPINS-1:0] s1;
      logic [GPJ_NPINS-1:0] s2;
      logic [GPJ_NPINS-1:0] s3;
      logic [GPJ_NPINS-1:0] lvl;
   } gpj_sync_st_t;

   gpj_sync_st_t st_q;
   gpj_sync_st_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.s1 = din;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      // First stage only feeds the second; filter sees stages two and three
      for (int i = 0; i < GPJ_NPINS; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.lvl[i] = st_q.s3[i];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign dout = st_q.lvl;
endmodule

// ---- src/gpj_port.sv ----
// Five-bit general-purpose port with timer output and external interrupt inputs
`timescale 1ns/10ps
// Operation
// - Five pins, each with its own input and output enable.
// - Reset leaves every pin general-purpose with input, output and pull-up off and all control bits zero.
// - With interrupt function and input enabled, the interrupt input stays live in stop even with pin drive off.
// - Outside stop an enabled input feeds its interrupt line whatever the function select; software masks unused ones.
// - Registers decode at base 0x4000_0240: data 0x0, output 0x4, function 0x8, pull-up 0x2c, input 0x38.
// - Data register holds pin bits 4-0, bits 31-8 read zero, bits 7-5 written as zero; the code stores bits 7-5 as written and reads them as zero.
// - Output control bit one turns the pin driver on.
// - Function bit one routes the timer output to pin 4 and pins 3-0 to external interrupts 3-0.
// - Pull-up control bit one turns the pin pull-up on.
// - Input control bit one opens the input buffer, zero blocks input and interrupt paths.
module gpj_port
   import gpj_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Pins
   input wire logic [GPJ_NPINS-1:0] port_pins_in,
   output logic [GPJ_NPINS-1:0] port_pins_out,
   output logic [GPJ_NPINS-1:0] port_pins_oe,
   output logic [GPJ_NPINS-1:0] port_pins_pullup,
   output logic [GPJ_NPINS-1:0] port_pins_ibuf_en,
   // Chip side
   input wire logic timer_six_output,
   input wire logic stop_mode,
   input wire logic stop_pin_drive_bit,
   output logic [GPJ_NIRQ-1:0] ext_irq,
   output logic irq
);
   typedef struct packed {
      gpj_regs_t regs;
      gpj_phase_t phase;
      logic [11:0] addr;
      logic [31:0] rdata;
      logic [GPJ_NIRQ-1:0] irq_stat;
      logic [GPJ_NIRQ-1:0] irq_mask;
      logic [GPJ_NIRQ-1:0] irq_prev;
      logic [GPJ_NIRQ-1:0] ext_irq;
      gpj_pad_t pad;
      logic irq;
   } gpj_state_t;

   gpj_state_t st_q;
   gpj_state_t st_d;
   logic [GPJ_NPINS-1:0] pin_level;

   gpj_sync u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .din(port_pins_in),
      .dout(pin_level)
   );

   // Low byte of a register word; bits above read as zero
   function automatic logic [31:0] gpj_rd8(input logic [7:0] v);
      gpj_rd8 = {24'h000000, v};
   endfunction

   // Base is not aligned to the window size, so decode by distance from the base
   function automatic logic gpj_hit(input logic [31:0] a);
      gpj_hit = (a - GPJ_BASE_ADDR) <= 32'(GPJ_ADDR_MASK);
   endfunction

   logic [GPJ_NIRQ-1:0] irq_live;
   logic [GPJ_NIRQ-1:0] irq_rise;
   logic [GPJ_NPINS-1:0] data_rd;
   logic [GPJ_NPINS-1:0] out_mux;
   logic [GPJ_NPINS-1:0] oe_eff;
   logic in_stop;

   always_comb begin
      st_d = st_q;
      in_stop = stop_mode;
      // Interrupt lines gated by input enable only; stop requires the function too
      for (int i = 0; i < GPJ_NIRQ; i++) begin
         if (in_stop) begin
            irq_live[i] = st_q.regs.ie[i] & st_q.regs.func[i] & pin_level[i];
         end else begin
            irq_live[i] = st_q.regs.ie[i] & pin_level[i];
         end
      end
      irq_rise = irq_live & ~st_q.irq_prev;
      st_d.irq_prev = irq_live;
      st_d.ext_irq = irq_live;

      // Sampled level where the input buffer is on, latch otherwise
      data_rd = (pin_level & st_q.regs.ie[GPJ_NPINS-1:0])
              | (st_q.regs.data[GPJ_NPINS-1:0] & ~st_q.regs.ie[GPJ_NPINS-1:0]);

      // Output mux: pin 4 may carry the timer
      out_mux = st_q.regs.data[GPJ_NPINS-1:0];
      if (st_q.regs.func[GPJ_TIMER_PIN]) begin
         out_mux[GPJ_TIMER_PIN] = timer_six_output;
      end
      oe_eff = st_q.regs.oe[GPJ_NPINS-1:0];
      // Stop with drive off releases every driver; interrupt inputs with function select set stay live
      if (in_stop && !stop_pin_drive_bit) begin
         oe_eff = '0;
      end
      st_d.pad.out = out_mux;
      st_d.pad.oe = oe_eff;
      st_d.pad.pup = st_q.regs.pup[GPJ_NPINS-1:0];
      st_d.pad.ibuf = st_q.regs.ie[GPJ_NPINS-1:0];

      // Sticky status; a new edge wins over a write-one clear
      st_d.irq_stat = st_q.irq_stat;

      case (st_q.phase)
         GPJ_WDATA: begin
            if (st_q.addr == GPJ_OFS_DATA) begin
               st_d.regs.data = hwdata[7:0] & GPJ_WBYTE_MASK;
            end else if (st_q.addr == GPJ_OFS_OE) begin
               st_d.regs.oe = hwdata[7:0];
            end else if (st_q.addr == GPJ_OFS_FUNC) begin
               st_d.regs.func = hwdata[7:0];
            end else if (st_q.addr == GPJ_OFS_PUP) begin
               st_d.regs.pup = hwdata[7:0];
            end else if (st_q.addr == GPJ_OFS_IE) begin
               st_d.regs.ie = hwdata[7:0];
            end else if (st_q.addr == GPJ_OFS_IRQ_STAT) begin
               st_d.irq_stat = st_q.irq_stat & ~hwdata[GPJ_NIRQ-1:0];
            end else if (st_q.addr == GPJ_OFS_IRQ_MASK) begin
               st_d.irq_mask = hwdata[GPJ_NIRQ-1:0];
            end
         end
         default: begin
         end
      endcase
      st_d.irq_stat = st_d.irq_stat | irq_rise;
      st_d.irq = |(st_d.irq_stat & st_d.irq_mask);

      // Address phase; reserved and unmapped words read zero and ignore writes
      st_d.phase = GPJ_IDLE;
      st_d.rdata = '0;
      if (hsel && hready && (htrans == GPJ_HTRANS_NONSEQ || htrans == GPJ_HTRANS_SEQ)) begin
         st_d.addr = 12'(haddr - GPJ_BASE_ADDR);
         if (!gpj_hit(haddr)) begin
            st_d.addr = GPJ_OFS_RSVD;
         end
         if (hwrite) begin
            st_d.phase = GPJ_WDATA;
         end else begin
            st_d.phase = GPJ_RDATA;
            if (st_d.addr == GPJ_OFS_DATA) begin
               st_d.rdata = gpj_rd8({3'h0, data_rd});
            end else if (st_d.addr == GPJ_OFS_OE) begin
               st_d.rdata = gpj_rd8(st_d.regs.oe);
            end else if (st_d.addr == GPJ_OFS_FUNC) begin
               st_d.rdata = gpj_rd8(st_d.regs.func);
            end else if (st_d.addr == GPJ_OFS_PUP) begin
               st_d.rdata = gpj_rd8(st_d.regs.pup);
            end else if (st_d.addr == GPJ_OFS_IE) begin
               st_d.rdata = gpj_rd8(st_d.regs.ie);
            end else if (st_d.addr == GPJ_OFS_IRQ_STAT) begin
               st_d.rdata = gpj_rd8({4'h0, st_d.irq_stat});
            end else if (st_d.addr == GPJ_OFS_IRQ_MASK) begin
               st_d.rdata = gpj_rd8({4'h0, st_d.irq_mask});
            end else if (st_d.addr == GPJ_OFS_CTRL) begin
               st_d.rdata = gpj_rd8({6'h00, stop_pin_drive_bit, in_stop});
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign hrdata = st_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign port_pins_out = st_q.pad.out;
   assign port_pins_oe = st_q.pad.oe;
   assign port_pins_pullup = st_q.pad.pup;
   assign port_pins_ibuf_en = st_q.pad.ibuf;
   assign ext_irq = st_q.ext_irq;
   assign irq = st_q.irq;
endmodule

// ---- testbench/gpj_board.sv ----
// Board model: wire levels on the five port pins
`timescale 1ns/10ps
module gpj_board (
   // Port side
   input wire logic [4:0] port_pins_out,
   input wire logic [4:0] port_pins_oe,
   input wire logic [4:0] port_pins_pullup,
   // Board side
   input wire logic [4:0] ext_en,
   input wire logic [4:0] ext_val,
   output logic [4:0] port_pins_in
);
   // Floating pin shows the inverse, so no unknown settles by chance
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         port_pins_in[i] = port_pins_oe[i] ? port_pins_out[i] :
            ext_en[i] ? ext_val[i] : port_pins_pullup[i] | ~ext_val[i];
      end
   end
endmodule

// ---- testbench/gpj_port_asserts.sv ----
// Checker on the five-bit port's own ports
`timescale 1ns/10ps
module gpj_port_asserts
   import gpj_pkg::*;
(
   // Bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   // Pins and chip side
   input wire logic [4:0] port_pins_in,
   input wire logic [4:0] port_pins_oe,
   input wire logic [4:0] port_pins_pullup,
   input wire logic [4:0] port_pins_ibuf_en,
   input wire logic stop_mode,
   input wire logic stop_pin_drive_bit,
   input wire logic [3:0] ext_irq
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire logic [11:0] ofs = 12'(haddr - GPJ_BASE_ADDR);
   wire logic take = hsel && htrans[1] && hreadyout;
   property p_rsvd; take && !hwrite && ofs == GPJ_OFS_RSVD |=> hrdata == 32'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved read");
   property p_dhi; take && !hwrite && ofs == GPJ_OFS_DATA |=> hrdata[31:5] == 27'h0; endproperty
   a_dhi: assert property (p_dhi) else $error("data high bits");
   property p_pup; take && hwrite && ofs == GPJ_OFS_PUP |=> ##2 port_pins_pullup == $past(hwdata[4:0], 2); endproperty
   a_pup: assert property (p_pup) else $error("pullup pins");
   property p_ie; take && hwrite && ofs == GPJ_OFS_IE |=> ##2 port_pins_ibuf_en == $past(hwdata[4:0], 2); endproperty
   a_ie: assert property (p_ie) else $error("input enables");
   property p_oe; take && hwrite && ofs == GPJ_OFS_OE && !stop_mode |=> ##2 port_pins_oe == $past(hwdata[4:0], 2);
   endproperty
   a_oe: assert property (p_oe) else $error("driver enables");
   property p_blk; (ext_irq & ~port_pins_ibuf_en[3:0] & ~$past(port_pins_ibuf_en[3:0])) == 4'h0; endproperty
   a_blk: assert property (p_blk) else $error("blocked irq");
   property p_low; (port_pins_in[3:0] == 4'h0) [*8] |-> ext_irq == 4'h0; endproperty
   a_low: assert property (p_low) else $error("irq from low pin");
   property p_stop; (stop_mode && !stop_pin_drive_bit) [*2] |-> port_pins_oe == 5'h0; endproperty
   a_stop: assert property (p_stop) else $error("drive in stop");
   c_wr: cover property (take && hwrite);
   c_irq: cover property (ext_irq != 4'h0);
   c_stop: cover property (stop_mode && !stop_pin_drive_bit);
endmodule
bind gpj_port gpj_port_asserts u_chk (.*);

// ---- testbench/test_five_bit_port_with_ext_interrupts.sv ----
// Bench for the five-bit port
`timescale 1ns/10ps
module test_five_bit_port_with_ext_interrupts
   import gpj_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic timer_six_output, stop_mode, stop_pin_drive_bit;
   logic [1:0] htrans;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr, hwdata, hrdata;
   logic [4:0] ext_en, ext_val, port_pins_in, port_pins_out, port_pins_oe, port_pins_pullup, port_pins_ibuf_en;
   logic [3:0] ext_irq;
   logic [31:0] m [128] = '{default: 32'h0};
   int ofs [7] = '{0, 4, 8, 'h2c, 'h38, 'h10, 'h3c};
   int err_total, n_tests;
   integer seed = 32'hc26f26fe;
   gpj_port dut (.hready(hreadyout), .*);
   gpj_board board (.*);
   always #4 hclk = ~hclk;
   task automatic give_verdict();
      $display("checks %0d errs %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] v, input logic [31:0] x);
      n_tests++;
      if (v !== x) begin
         err_total++;
         $display("[ERR] %s exp %h seen %h", s, x, v);
      end
   endtask
   task automatic wt();
      int n = 0;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 64);
      if (n >= 64) begin
         err_total++;
         give_verdict();
      end
   endtask
   task automatic bus(input logic wr, input int a, input logic [31:0] d);
      logic [31:0] e;
      hsel <= 1'b1;
      htrans <= GPJ_HTRANS_NONSEQ;
      haddr <= GPJ_BASE_ADDR + 32'(a);
      hwrite <= wr;
      wt();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt();
      e = m[a];
      // Input-enabled data bits read the pin, others the latch
      if (a == 0) e = (e & ~m['h38] | 32'(port_pins_in) & m['h38]) & 32'h1f;
      if (!wr) chk("rdata", hrdata, e);
      else if (a inside {0, 4, 8, 'h2c, 'h38}) m[a] = d & 32'hff;
   endtask
   task automatic pins();
      repeat (3) @(posedge hclk);
      chk("pup", 32'(port_pins_pullup), m['h2c]);
      chk("oe", 32'(port_pins_oe), m[4]);
      chk("ibuf", 32'(port_pins_ibuf_en), m['h38]);
      chk("out", 32'(port_pins_out), 32'({m[8][4] ? timer_six_output : m[0][4], m[0][3:0]}));
   endtask
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata, timer_six_output, stop_mode, stop_pin_drive_bit, ext_en, ext_val} = '0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (ofs[i]) bus(1'b0, ofs[i], 32'h0);
      pins();
      for (int k = 0; k < 60; k++) begin
         {stop_pin_drive_bit, timer_six_output, ext_en, ext_val} <= 12'($random(seed));
         repeat (8) @(posedge hclk);
         bus(1'($random(seed)), ofs[{$random(seed)} % 7], $random(seed) & 32'h1f);
         pins();
      end
      // Pin 0 edge: run mode, then stop with drive off, without and with function select
      ext_en <= 5'h1f;
      ext_val <= 5'h0;
      bus(1'b1, 4, 32'h0);
      bus(1'b1, 'h38, 32'h1);
      bus(1'b1, 'h44, 32'h1);
      for (int s = 0; s < 3; s++) begin
         stop_mode <= (s > 0);
         stop_pin_drive_bit <= 1'b0;
         bus(1'b1, 8, 32'(s == 2));
         repeat (8) @(posedge hclk);
         bus(1'b1, 'h40, 32'hf);
         ext_val <= 5'h1;
         repeat (8) @(posedge hclk);
         chk("irq", 32'(irq), 32'(s != 1));
         ext_val <= 5'h0;
      end
      bus(1'b1, 'h44, 32'h0);
      repeat (3) @(posedge hclk);
      chk("irq_mask", 32'(irq), 32'h0);
      give_verdict();
   end
endmodule
